// ### verification/ptt_far_model.sv
`default_nettype none
module ptt_far_model (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [1:0] i_pin_lvl,
    output logic [31:0] o_sys_ns,
    output logic [1:0] o_ts_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // time counter
    // 40 ns steps from a 16 ns offset: every capture lands in slot 2 of its 40 ns period
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_sys_ns <= 32'h0000_0010;
        end else begin
            o_sys_ns <= o_sys_ns + 32'h0000_0028;
        end
    end
    // ==========================================
    // event pins
    // levels move only on clock edges and hold for several clocks, well inside the input rate
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_ts_in <= 2'h0;
        end else begin
            o_ts_in <= i_pin_lvl;
        end
    end
endmodule
`default_nettype wire

// ### verification/tb.sv
`default_nettype none
module tb
    import ptt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    ptt_bus_s bus = '0;
    logic [1:0] pin = 2'h0;
    wire logic [31:0] sys_ns;
    wire logic [1:0] ts_in;
    logic [31:0] rdata;
    logic [2:0] trig;
    logic [31:0] d;
    int err_count = 0;
    int comparisons = 0;
    int n, g;
    ptt_top #(.N_TRIG(3), .N_TS(2)) i_ptt_top (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_ce(1'b1), .i_bus(bus), .i_sys_ns(sys_ns), .i_ts_in(ts_in), .o_rdata(rdata),
        .o_trig(trig));
    ptt_far_model i_ptt_far_model (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_pin_lvl(pin), .o_sys_ns(sys_ns), .o_ts_in(ts_in));
    initial begin
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    // ==========================================
    // bus and compare helpers
    // strobes drop for one idle cycle so no strobe is assigned twice in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge i_clk_sys);
        bus.wr <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge i_clk_sys);
        bus.rd <= 1'b0;
        #1;
        v = rdata;
        @(posedge i_clk_sys);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        comparisons++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task automatic pulse(input int u, input int cnt);
        repeat (cnt) begin
            pin[u] <= 1'b1;
            repeat (4) @(posedge i_clk_sys);
            pin[u] <= 1'b0;
            repeat (4) @(posedge i_clk_sys);
        end
        repeat (6) @(posedge i_clk_sys);
    endtask
    task automatic arm(input logic [1:0] u, input logic [2:0] m, input logic [31:0] pw,
        input logic [31:0] loop);
        wr(OFF_INDEX, {30'h0, u});
        wr(OFF_PULSE_W, pw);
        wr(OFF_LOOP, loop);
        wr(OFF_TARGET, sys_ns + 32'h0000_0320);
        wr(OFF_TRIG_CTRL, 32'h8000_0000 | (32'(m) << MODE_LSB));
    endtask
    task automatic width(input int u, input int lim, output int hi);
        int k;
        hi = 0;
        k = 0;
        while (trig[u] !== 1'b1 && k < lim) begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end
        while (trig[u] === 1'b1 && hi < lim) begin
            @(posedge i_clk_sys);
            #1;
            hi++;
        end
    endtask
    task automatic rises(input int u, input int span, output int cnt, output int gap);
        logic prev;
        int t1;
        cnt = 0;
        gap = 0;
        t1 = 0;
        prev = trig[u];
        for (int k = 0; k < span; k++) begin
            @(posedge i_clk_sys);
            #1;
            if (trig[u] === 1'b1 && prev === 1'b0) begin
                cnt++;
                if (cnt == 1) t1 = k;
                if (cnt == 2) gap = k - t1;
            end
            prev = trig[u];
        end
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs;
        rc(OFF_CYCLE_W, 32'h0);
        rc(OFF_LOOP, 32'h0);
        rc(OFF_TS_STAT, 32'h0);
        rc(OFF_TS_NS, 32'h0);
        wr(12'h600, 32'hFFFF_FFFF);
        rc(12'h600, 32'h0);
        wr(OFF_CYCLE_W, 32'h0000_0050);
        rc(OFF_CYCLE_W, 32'h0000_0050);
        for (int u = 0; u < 3; u++) begin
            wr(OFF_INDEX, 32'(u));
            wr(OFF_CNT_PAT, {16'(u + 1), 16'hA5C0 | 16'(u)});
            wr(OFF_PULSE_W, 32'hFF00_0010 | (32'(u) << 16));
        end
        for (int u = 0; u < 3; u++) begin
            wr(OFF_INDEX, 32'(u));
            rc(OFF_CNT_PAT, {16'(u + 1), 16'hA5C0 | 16'(u)});
            rc(OFF_PULSE_W, 32'h0000_0010 | (32'(u) << 16));
        end
        wr(OFF_INDEX, 32'h3);
        rc(OFF_CNT_PAT, 32'h0);
        wr(OFF_TS_NS, 32'hFFFF_FFFF);
        rc(OFF_TS_NS, 32'h0);
    endtask
    task automatic t_capture;
        logic [31:0] t0;
        wr(OFF_INDEX, 32'h0);
        wr(OFF_TS_STAT, 32'h0000_0080);
        t0 = sys_ns;
        pulse(0, 2);
        rc(OFF_TS_STAT, 32'h0004_0080);
        rd(OFF_TS_NS, d);
        chk(d[30], 1'b1);
        chk_rng(d[29:0], t0, t0 + 32'd400);
        rc(OFF_TS_PHASE, 32'h2);
        wr(OFF_INDEX, 32'h0000_0100);
        wr(OFF_TS_STAT, 32'h0000_0040);
        t0 = sys_ns;
        pulse(1, 3);
        rc(OFF_TS_STAT, 32'h0006_0040);
        rd(OFF_TS_NS, d);
        chk(d[30], 1'b0);
        chk_rng(d[29:0], t0 + 32'd160, t0 + 32'd560);
    endtask
    task automatic t_overflow;
        wr(OFF_INDEX, 32'h0);
        wr(OFF_TS_STAT, 32'h0000_0081);
        pulse(0, 17);
        rc(OFF_TS_STAT, 32'h001E_0081);
        wr(OFF_TS_STAT, 32'h0000_00A1);
        pulse(0, 17);
        rc(OFF_TS_STAT, 32'h001F_00A1);
        wr(OFF_TS_STAT, 32'h0000_00C0);
        pulse(0, 9);
        rc(OFF_TS_STAT, 32'h001F_00C0);
        wr(OFF_TS_STAT, 32'h0);
        pulse(0, 1);
        rc(OFF_TS_STAT, 32'h0);
    endtask
    task automatic t_modes;
        logic [2:0] md [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        for (int i = 0; i < 5; i++) begin
            arm(2'h0, md[i], 32'h2, 32'h0);
            #1;
            chk(trig[0], md[i] == 3'h0 || md[i] == 3'h2);
            repeat (40) @(posedge i_clk_sys);
            #1;
            chk(trig[0], md[i] == 3'h1 || md[i] == 3'h2);
            rc(OFF_TRIG_CTRL, 32'(md[i]) << MODE_LSB);
        end
    endtask
    task automatic t_widths;
        arm(2'h0, 3'h3, 32'd25, 32'h0);
        width(0, 100, n);
        chk_rng(n, 4, 6);
        wr(OFF_CYCLE_W, 32'd400);
        wr(OFF_CNT_PAT, 32'h0003_0000);
        arm(2'h0, 3'h5, 32'd10, 32'h0);
        rises(0, 300, n, g);
        chk(n, 3);
        chk(g, 10);
        arm(2'h0, 3'h3, 32'd5, 32'd2000);
        rises(0, 130, n, g);
        chk(g, 50);
        wr(OFF_TRIG_CTRL, 32'h0);
        arm(2'h2, 3'h3, 32'h0001_0000, 32'h0);
        width(2, 20000, n);
        chk_rng(n, 13105, 13110);
    endtask
    task automatic t_pattern;
        int k;
        wr(OFF_INDEX, 32'h0);
        wr(OFF_CYCLE_W, 32'd400);
        wr(OFF_CNT_PAT, 32'h0004_A000);
        arm(2'h0, 3'h6, 32'h0, 32'h0);
        rises(0, 120, n, g);
        chk(n, 2);
        chk(g, 20);
        arm(2'h1, 3'h3, 32'd10, 32'h0);
        k = 0;
        while (trig[1] !== 1'b1 && k < 100) begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end
        chk(k, 14);
    endtask
    task automatic t_chain;
        wr(OFF_INDEX, 32'h0000_0100);
        wr(OFF_TS_STAT, 32'h0000_0083);
        wr(OFF_INDEX, 32'h0);
        wr(OFF_TS_STAT, 32'h0000_00A3);
        pulse(0, 2);
        rc(OFF_TS_STAT, 32'h0000_00A3);
        wr(OFF_INDEX, 32'h0000_0100);
        pulse(1, 15);
        rc(OFF_TS_STAT, 32'h001E_0083);
        wr(OFF_INDEX, 32'h0);
        pulse(0, 2);
        rc(OFF_TS_STAT, 32'h0004_00A3);
    endtask
    task automatic stop_test;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        @(posedge i_clk_sys);
        t_regs();
        t_capture();
        t_overflow();
        t_modes();
        t_widths();
        t_pattern();
        t_chain();
        stop_test();
    end
    initial begin
        #(100 * 60000);
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire

// ### verilog/ptt_pkg.sv
`default_nettype none
package ptt_pkg;
    // ==========================================
    // clock and timing
    localparam int unsigned CLK_NS = 100;
    localparam int unsigned PW_UNIT_NS = 8;
    localparam int unsigned TS_RATE_NS = 40;
    localparam int unsigned SLOT_NS = 8;
    localparam int unsigned TS_SLOTS = TS_RATE_NS / SLOT_NS;
    // ==========================================
    // register byte addresses
    localparam logic [11:0] OFF_INDEX = 12'h520;
    localparam logic [11:0] OFF_TRIG_CTRL = 12'h528;
    localparam logic [11:0] OFF_TARGET = 12'h52C;
    localparam logic [11:0] OFF_CYCLE_W = 12'h53C;
    localparam logic [11:0] OFF_CNT_PAT = 12'h540;
    localparam logic [11:0] OFF_LOOP = 12'h544;
    localparam logic [11:0] OFF_PULSE_W = 12'h548;
    localparam logic [11:0] OFF_TS_STAT = 12'h550;
    localparam logic [11:0] OFF_TS_NS = 12'h554;
    localparam logic [11:0] OFF_TS_PHASE = 12'h55C;
    // ==========================================
    // field positions
    localparam int TRIG_PTR_LSB = 0;
    localparam int TS_PTR_BIT = 8;
    localparam int OUT_UNIT_ENABLE_BIT = 31;
    localparam int MODE_LSB = 20;
    localparam int COUNT_LSB = 16;
    localparam int PAT_LSB = 0;
    localparam int EXT_LSB = 16;
    localparam int PW_LSB = 0;
    localparam int RISE_BIT = 7;
    localparam int FALL_BIT = 6;
    localparam int TAIL_BIT = 5;
    localparam int USEL_BIT = 1;
    localparam int CEN_BIT = 0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam int PPS_UNIT = 2;
    localparam int COMP_UNIT = 1;
    // ==========================================
    // types
    typedef enum logic [2:0] {
        MD_NEG_EDGE, MD_POS_EDGE, MD_NEG_PULSE, MD_POS_PULSE,
        MD_NEG_PER, MD_POS_PER, MD_PATTERN, MD_RSVD
    } ptt_mode_e;
    typedef enum logic [1:0] {TR_IDLE, TR_WAIT, TR_RUN} ptt_tstate_e;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ptt_bus_s;
    typedef struct packed {
        logic out_unit_enable;
        ptt_mode_e mode;
        logic [31:0] target;
        logic [15:0] count;
        logic [15:0] pattern;
        logic [31:0] chain_loop_time;
        logic [7:0] second_pulse_width_ext;
        logic [15:0] pw;
        ptt_tstate_e st;
        logic lvl;
        logic [31:0] t_cyc;
        logic [15:0] done_n;
        logic [3:0] bit_i;
    } ptt_trig_s;
    typedef struct packed {
        logic capture_rise_en;
        logic capture_fall_en;
        logic chain_last_unit;
        logic chain_upstream_sel;
        logic chain_en;
        logic [3:0] capture_event_count;
        logic capture_count_overflow;
        logic first_sample_edge;
        logic [29:0] first_sample_nanosec;
        logic [2:0] first_sample_phase;
        logic [2:0] sync;
        logic lvl;
    } ptt_ts_s;
endpackage
`default_nettype wire

// ### verilog/ptt_top.sv
`default_nettype none
module ptt_top
    import ptt_pkg::*;
#(
    parameter int N_TRIG = 3,
    parameter int N_TS = 2
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire ptt_bus_s i_bus,
    input wire logic [31:0] i_sys_ns,
    input wire logic [N_TS-1:0] i_ts_in,
    output logic [31:0] o_rdata,
    output logic [N_TRIG-1:0] o_trig
);
    // ==========================================
    // elaboration checks
    if (N_TRIG < 1 || N_TRIG > 4) begin : g_chk_trig
        $error("N_TRIG must be 1 to 4");
    end
    // the upstream select is one bit wide, so the chain holds exactly two units
    if (N_TS != 2) begin : g_chk_ts
        $error("N_TS must be 2");
    end

    typedef struct packed {
        logic [1:0] idx_trig;
        logic idx_ts;
        logic [31:0] cyc_w;
        ptt_trig_s [N_TRIG-1:0] tr;
        ptt_ts_s [N_TS-1:0] ts;
        logic [31:0] rdata;
    } ptt_state_s;

    ptt_state_s st_reg;
    ptt_state_s st_next;
    ptt_trig_s t;
    ptt_trig_s tsel;
    ptt_ts_s s;
    ptt_ts_s ssel;
    ptt_ts_s up;
    logic [31:0] pw;
    logic [31:0] tgt;
    logic [31:0] el;
    logic fin;
    logic act;
    logic idl;
    logic agree;
    logic hit;
    logic fed;

    function automatic logic ptt_idle(input ptt_mode_e m);
        ptt_idle = (m == MD_NEG_EDGE || m == MD_NEG_PULSE || m == MD_NEG_PER);
    endfunction

    function automatic logic [31:0] ptt_pw_ns(input ptt_trig_s x, input int u);
        logic [23:0] w;
        w = {8'h00, x.pw};
        if (u == PPS_UNIT) begin
            w = {x.second_pulse_width_ext, x.pw};
        end
        ptt_pw_ns = 32'(w) * 32'(PW_UNIT_NS);
    endfunction

    // ==========================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.rdata = '0;
        tsel = '0;
        ssel = '0;
        t = '0;
        s = '0;
        up = '0;
        pw = '0;
        tgt = '0;
        el = '0;
        fin = 1'b0;
        act = 1'b0;
        idl = 1'b0;
        agree = 1'b0;
        hit = 1'b0;
        fed = 1'b0;
        for (int i = 0; i < N_TRIG; i++) begin
            t = st_reg.tr[i];
            pw = ptt_pw_ns(t, i);
            tgt = t.target;
            if (i == COMP_UNIT) begin
                // path delay compensation: fire early by the programmed delay
                tgt = t.target - 32'({t.second_pulse_width_ext, t.pw}) * 32'(PW_UNIT_NS);
            end
            el = i_sys_ns - t.t_cyc;
            idl = ptt_idle(t.mode);
            act = !idl;
            fin = 1'b0;
            case (t.st)
                TR_WAIT: begin
                    if ($signed(i_sys_ns - tgt) >= 0) begin
                        t.t_cyc = tgt;
                        t.done_n = '0;
                        t.bit_i = '0;
                        t.st = TR_RUN;
                        case (t.mode)
                            MD_NEG_EDGE: begin
                                t.lvl = 1'b0;
                                fin = 1'b1;
                            end
                            MD_POS_EDGE: begin
                                t.lvl = 1'b1;
                                fin = 1'b1;
                            end
                            MD_PATTERN: t.lvl = t.pattern[4'hF];
                            MD_RSVD: fin = 1'b1;
                            default: t.lvl = act;
                        endcase
                    end
                end
                TR_RUN: begin
                    if (t.mode == MD_NEG_PULSE || t.mode == MD_POS_PULSE) begin
                        if (el >= pw) begin
                            t.lvl = idl;
                            fin = 1'b1;
                        end
                    end else if (el >= st_reg.cyc_w) begin
                        t.t_cyc = t.t_cyc + st_reg.cyc_w;
                        t.bit_i = t.bit_i + 4'h1;
                        t.done_n = t.done_n + 16'h0001;
                        if (t.count != 16'h0000 && t.done_n == t.count) begin
                            t.lvl = idl;
                            fin = 1'b1;
                        end else if (t.mode == MD_PATTERN) begin
                            t.lvl = t.pattern[~t.bit_i];
                        end else begin
                            t.lvl = act;
                        end
                    end else if (t.mode != MD_PATTERN) begin
                        t.lvl = (el < pw) ? act : idl;
                    end
                end
                default: ;
            endcase
            if (fin) begin
                if (t.chain_loop_time != 32'h0000_0000) begin
                    t.target = t.target + t.chain_loop_time;
                    t.st = TR_WAIT;
                end else begin
                    t.st = TR_IDLE;
                    t.out_unit_enable = 1'b0;
                end
            end
            if (i_bus.wr && st_reg.idx_trig == 2'(i)) begin
                if (i_bus.addr == OFF_TRIG_CTRL) begin
                    t.out_unit_enable = i_bus.wdata[OUT_UNIT_ENABLE_BIT];
                    t.mode = ptt_mode_e'(i_bus.wdata[MODE_LSB +: 3]);
                    t.st = t.out_unit_enable ? TR_WAIT : TR_IDLE;
                    t.lvl = ptt_idle(t.mode);
                end else if (i_bus.addr == OFF_TARGET) begin
                    t.target = i_bus.wdata;
                end else if (i_bus.addr == OFF_CNT_PAT) begin
                    t.count = i_bus.wdata[COUNT_LSB +: 16];
                    t.pattern = i_bus.wdata[PAT_LSB +: 16];
                end else if (i_bus.addr == OFF_LOOP) begin
                    t.chain_loop_time = i_bus.wdata;
                end else if (i_bus.addr == OFF_PULSE_W) begin
                    t.second_pulse_width_ext = i_bus.wdata[EXT_LSB +: 8];
                    t.pw = i_bus.wdata[PW_LSB +: 16];
                end
            end
            if (st_reg.idx_trig == 2'(i)) begin
                tsel = st_reg.tr[i];
            end
            st_next.tr[i] = t;
        end

        for (int i = 0; i < N_TS; i++) begin
            s = st_reg.ts[i];
            // three-stage synchroniser; the first stage feeds only the second
            s.sync = {st_reg.ts[i].sync[1:0], i_ts_in[i]};
            agree = st_reg.ts[i].sync[1] == st_reg.ts[i].sync[2];
            hit = 1'b0;
            if (agree && st_reg.ts[i].sync[2] != st_reg.ts[i].lvl) begin
                s.lvl = st_reg.ts[i].sync[2];
                hit = s.lvl ? st_reg.ts[i].capture_rise_en
                            : st_reg.ts[i].capture_fall_en;
            end
            up = st_reg.ts[st_reg.ts[i].chain_upstream_sel];
            // a unit whose select points at itself is the chain head
            fed = !st_reg.ts[i].chain_en
                  || st_reg.ts[i].chain_upstream_sel == 1'(i)
                  || up.capture_event_count == CNT_MAX;
            if (i_bus.wr && i_bus.addr == OFF_TS_STAT && st_reg.idx_ts == 1'(i)) begin
                s.capture_rise_en = i_bus.wdata[RISE_BIT];
                s.capture_fall_en = i_bus.wdata[FALL_BIT];
                s.chain_last_unit = i_bus.wdata[TAIL_BIT];
                s.chain_upstream_sel = i_bus.wdata[USEL_BIT];
                s.chain_en = i_bus.wdata[CEN_BIT];
                // rearm; an edge in this same cycle is still counted below
                s.capture_event_count = '0;
                s.capture_count_overflow = 1'b0;
            end
            if (hit && fed) begin
                if (s.capture_event_count == 4'h0) begin
                    s.first_sample_nanosec = i_sys_ns[29:0];
                    s.first_sample_edge = s.lvl;
                    s.first_sample_phase =
                        3'((i_sys_ns % 32'(TS_RATE_NS)) / 32'(SLOT_NS));
                end
                if (s.capture_event_count == CNT_MAX) begin
                    if (!s.chain_en || s.chain_last_unit) begin
                        s.capture_count_overflow = 1'b1;
                    end
                end else begin
                    s.capture_event_count = s.capture_event_count + 4'h1;
                end
            end
            if (st_reg.idx_ts == 1'(i)) begin
                ssel = st_reg.ts[i];
            end
            st_next.ts[i] = s;
        end

        // ==========================================
        // register bus
        if (i_bus.wr) begin
            if (i_bus.addr == OFF_INDEX) begin
                st_next.idx_trig = i_bus.wdata[TRIG_PTR_LSB +: 2];
                st_next.idx_ts = i_bus.wdata[TS_PTR_BIT];
            end else if (i_bus.addr == OFF_CYCLE_W) begin
                st_next.cyc_w = i_bus.wdata;
            end
        end
        if (i_bus.rd) begin
            if (i_bus.addr == OFF_INDEX) begin
                st_next.rdata = {23'h000000, st_reg.idx_ts, 6'h00, st_reg.idx_trig};
            end else if (i_bus.addr == OFF_TRIG_CTRL) begin
                st_next.rdata = {tsel.out_unit_enable, 8'h00, tsel.mode, 18'h00000, tsel.st};
            end else if (i_bus.addr == OFF_TARGET) begin
                st_next.rdata = tsel.target;
            end else if (i_bus.addr == OFF_CYCLE_W) begin
                st_next.rdata = st_reg.cyc_w;
            end else if (i_bus.addr == OFF_CNT_PAT) begin
                st_next.rdata = {tsel.count, tsel.pattern};
            end else if (i_bus.addr == OFF_LOOP) begin
                st_next.rdata = tsel.chain_loop_time;
            end else if (i_bus.addr == OFF_PULSE_W) begin
                st_next.rdata = {8'h00, tsel.second_pulse_width_ext, tsel.pw};
            end else if (i_bus.addr == OFF_TS_STAT) begin
                st_next.rdata = {11'h000, ssel.capture_event_count,
                    ssel.capture_count_overflow, 8'h00, ssel.capture_rise_en,
                    ssel.capture_fall_en, ssel.chain_last_unit, 3'h0,
                    ssel.chain_upstream_sel, ssel.chain_en};
            end else if (i_bus.addr == OFF_TS_NS) begin
                st_next.rdata = {1'b0, ssel.first_sample_edge, ssel.first_sample_nanosec};
            end else if (i_bus.addr == OFF_TS_PHASE) begin
                st_next.rdata = {29'h00000000, ssel.first_sample_phase};
            end
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_reg <= '0;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rdata;

    // ==========================================
    // assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    idx_read_a: assert property (i_ce && i_bus.rd && i_bus.addr == OFF_INDEX
        |=> o_rdata[TS_PTR_BIT] == $past(st_reg.idx_ts))
        else $error("index read back wrong");
    pat_route_a: assert property (i_ce && i_bus.wr && i_bus.addr == OFF_CNT_PAT
        && st_reg.idx_trig == 2'h0 |=> st_reg.tr[0].pattern == $past(i_bus.wdata[15:0]))
        else $error("pattern write misrouted");
    cover property (st_reg.ts[0].capture_count_overflow);
    cover property (st_reg.tr[0].st == TR_RUN && st_reg.tr[0].mode == MD_PATTERN);
    cover property (st_reg.tr[0].st == TR_RUN ##1 st_reg.tr[0].st == TR_WAIT);
    cover property ($rose(o_trig[0]));
    cover property (st_reg.ts[1].capture_event_count == CNT_MAX);
    rdata_idle_a: assert property (i_ce && !i_bus.rd |=> o_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");

    for (genvar g = 0; g < N_TRIG; g++) begin : g_trig
        assign o_trig[g] = st_reg.tr[g].lvl;
        pos_edge_a: assert property (i_ce && !i_bus.wr && st_reg.tr[g].st == TR_WAIT
            && st_next.tr[g].st != TR_WAIT && st_reg.tr[g].mode == MD_POS_EDGE
            |=> st_reg.tr[g].lvl) else $error("positive edge not driven");
        pulse_end_a: assert property (i_ce && !i_bus.wr && st_reg.tr[g].st == TR_RUN
            && st_reg.tr[g].mode == MD_POS_PULSE
            && (i_sys_ns - st_reg.tr[g].t_cyc) >= ptt_pw_ns(st_reg.tr[g], g)
            |=> !st_reg.tr[g].lvl) else $error("pulse not ended");
        loop_add_a: assert property (i_ce && !i_bus.wr && st_reg.tr[g].st == TR_RUN
            ##1 st_reg.tr[g].st == TR_WAIT |-> st_reg.tr[g].target
            == $past(st_reg.tr[g].target) + $past(st_reg.tr[g].chain_loop_time))
            else $error("cascade target not advanced");
        // a bus write in the same cycle may legally move the unit, so it is excluded
        pat_msb_a: assert property (i_ce && !i_bus.wr && st_reg.tr[g].st == TR_WAIT
            && st_next.tr[g].st == TR_RUN && st_reg.tr[g].mode == MD_PATTERN
            |=> st_reg.tr[g].lvl == $past(st_reg.tr[g].pattern[4'hF]))
            else $error("pattern not started at top bit");
        idle_hold_a: assert property (i_ce && !i_bus.wr && st_reg.tr[g].st == TR_IDLE
            |=> $stable(st_reg.tr[g].lvl)) else $error("idle output moved");
    end

    for (genvar g = 0; g < N_TS; g++) begin : g_ts
        sat_hold_a: assert property (st_reg.ts[g].capture_count_overflow
            |-> st_reg.ts[g].capture_event_count == CNT_MAX)
            else $error("count not held at max");
        tail_ovf_a: assert property ($rose(st_reg.ts[g].capture_count_overflow)
            && $past(st_reg.ts[g].chain_en) |-> $past(st_reg.ts[g].chain_last_unit))
            else $error("non-tail unit overflowed");
        count_step_a: assert property (!$past(i_bus.wr)
            && st_reg.ts[g].capture_event_count != $past(st_reg.ts[g].capture_event_count)
            |-> st_reg.ts[g].capture_event_count
                == $past(st_reg.ts[g].capture_event_count) + 4'h1)
            else $error("count jumped");
        rise_gate_a: assert property ($past(st_reg.ts[g].capture_event_count) == 4'h0
            && st_reg.ts[g].capture_event_count == 4'h1 && st_reg.ts[g].first_sample_edge
            |-> $past(st_reg.ts[g].capture_rise_en)) else $error("rise not enabled");
        fall_gate_a: assert property ($past(st_reg.ts[g].capture_event_count) == 4'h0
            && st_reg.ts[g].capture_event_count == 4'h1 && !st_reg.ts[g].first_sample_edge
            |-> $past(st_reg.ts[g].capture_fall_en)) else $error("fall not enabled");
        gate_off_a: assert property (!i_bus.wr && !st_reg.ts[g].capture_rise_en
            && !st_reg.ts[g].capture_fall_en |=> $stable(st_reg.ts[g].capture_event_count))
            else $error("disabled unit counted");
        ovf_at_max_a: assert property ($rose(st_reg.ts[g].capture_count_overflow)
            |-> $past(st_reg.ts[g].capture_event_count) == CNT_MAX)
            else $error("overflow before count full");
        phase_range_a: assert property (st_reg.ts[g].first_sample_phase
            < 3'(TS_SLOTS)) else $error("phase code out of range");
    end
endmodule
`default_nettype wire
